//--- hw/setpoint_pkg.sv
package setpoint_pkg;
  // Pressure word width and range ends
  localparam int PW = 16;
  typedef logic [PW-1:0] pres_t;
  typedef logic [7:0] addr_t;
  localparam pres_t RANGE_MIN = 16'h0000;
  localparam pres_t RANGE_MAX = 16'hffff;

  // Trip modes and button adjust states
  typedef enum logic [1:0] {MODE_LOW, MODE_HIGH, MODE_BOTH} mode_t;
  typedef enum logic [1:0] {ADJ_IDLE, ADJ_HOLD, ADJ_WAIT} adj_t;

  typedef struct packed {
    logic high_en;
    logic low_en;
    mode_t mode;
  } sp_cfg_t;

  // Register port request, one strobe per cycle
  typedef struct packed {
    addr_t addr;
    pres_t wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // Register map, word addresses
  localparam addr_t A_CTRL = 8'h00;
  localparam addr_t A_STAT = 8'h01;
  localparam addr_t A_PRES = 8'h02;
  localparam int A_SP0 = 'h10;
  localparam int A_SP_STRIDE = 'h08;
  localparam int O_LTHR = 0;
  localparam int O_HTHR = 1;
  localparam int O_LHYS = 2;
  localparam int O_HHYS = 3;
  localparam int O_CFG = 4;

  // Field positions
  localparam int CTRL_FLIP_BIT = 0;
  localparam int STAT_RELAY_LSB = 0;
  localparam int STAT_ADJ_LSB = 2;
  localparam int STAT_VER_BIT = 4;
  localparam int CFG_LCUST_BIT = 4;
  localparam int CFG_HCUST_BIT = 5;

  // Values after reset
  localparam sp_cfg_t CFG_RST = '{high_en: 1'b1, low_en: 1'b1, mode: MODE_LOW};
  localparam int HYS_DIV = 10;
  localparam pres_t VERSION_CODE = 16'h0100; // Arbitrary value

  // Timing, in milliseconds, and derived cycle counts
  localparam int CLK_HZ = 40_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int DEB_MS = 20;
  localparam int STEP_MS = 100;
  localparam int BLINK_MS = 250;
  localparam int VER_MS = 2000;
  localparam int FINE_MS = 1000;
  localparam int REV_LO_MS = 2000;
  localparam int REV_HI_MS = 3000;
  localparam int SAVE_MS = 5000;
  localparam int DEB_CYC = DEB_MS * CYC_PER_MS;
  localparam int STEP_CYC = STEP_MS * CYC_PER_MS;
  localparam int BLINK_CYC = BLINK_MS * CYC_PER_MS;
  localparam int VER_CYC = VER_MS * CYC_PER_MS;
  localparam int FINE_CYC = FINE_MS * CYC_PER_MS;
  localparam int REV_LO_CYC = REV_LO_MS * CYC_PER_MS;
  localparam int REV_HI_CYC = REV_HI_MS * CYC_PER_MS;
  localparam int SAVE_CYC = SAVE_MS * CYC_PER_MS;
endpackage

//--- hw/pressure_setpoint_switch.sv
// Contract
// - Low mode: relay closes and LED lights while pressure is below threshold
// - Default hysteresis is a tenth of the threshold
// - High mode: relay closes and LED lights while pressure exceeds threshold
// - Combined mode: close above high threshold or below low threshold
// - After reset both thresholds sit at the bottom of the range
// - Release ten percent above low threshold, ten percent below high
// - Any button press restores the default hysteresis of that setpoint
// - Press enters adjust mode; threshold replaces the measurement output, marker blinks
// - While adjusting, show that threshold and flash the matching LED
// - Holding the button steps the threshold continuously up to the limit
// - Press again within one second: threshold moves exactly one unit
// - Press again between two and three seconds: direction reverses
// - Released over five seconds: threshold saved, back to measurement
// - Combined mode: buttons adjust only the low threshold
// - Second setpoint behaves exactly like the first; the first takes the outputs when both are adjusted
// - Mode changes only over the register port; hysteresis is written there and returns to its default on a button press
// - Each setpoint has seven settings: thresholds, enables, hystereses, mode
// - Each setpoint drives its own relay over the full range
// - Thresholds are readable and writable over the register port
// - Version code is shown briefly after power-up
// - Display orientation flips by a register command
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
module pressure_setpoint_switch #(
  parameter int DEB_CYC = setpoint_pkg::DEB_CYC,
  parameter int STEP_CYC = setpoint_pkg::STEP_CYC,
  parameter int BLINK_CYC = setpoint_pkg::BLINK_CYC,
  parameter int VER_CYC = setpoint_pkg::VER_CYC,
  parameter int FINE_CYC = setpoint_pkg::FINE_CYC,
  parameter int REV_LO_CYC = setpoint_pkg::REV_LO_CYC,
  parameter int REV_HI_CYC = setpoint_pkg::REV_HI_CYC,
  parameter int SAVE_CYC = setpoint_pkg::SAVE_CYC
) (
  input logic sys_clk,
  input logic rstn,
  input setpoint_pkg::bus_req_t bus_req,
  output setpoint_pkg::pres_t rdata,
  input setpoint_pkg::pres_t pressure,
  input logic [1:0] threshold_button,
  output logic first_threshold_switch,
  output logic second_threshold_switch,
  output logic [1:0] led,
  output setpoint_pkg::pres_t analog_out,
  output setpoint_pkg::pres_t display_value,
  output logic marker_blink,
  output logic display_flip,
  output logic show_version,
  output logic health_indicator,
  output logic [1:0] nvm_save
);
  import setpoint_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Address decode of a setpoint register, shared by write and read paths
  function automatic logic sp_hit(addr_t a, int n, int off);
    return a == addr_t'(A_SP0 + n * A_SP_STRIDE + off);
  endfunction

  function automatic pres_t tenth(pres_t v);
    return pres_t'(v / pres_t'(HYS_DIV));
  endfunction

  pres_t lthr_ff [2];
  pres_t hthr_ff [2];
  pres_t lhys_ff [2];
  pres_t hhys_ff [2];
  pres_t lhe [2];
  pres_t hhe [2];
  pres_t cur_thr [2];
  logic lcust_ff [2];
  logic hcust_ff [2];
  logic lo_act_ff [2];
  logic hi_act_ff [2];
  sp_cfg_t cfg_ff [2];
  adj_t st_ff [2];
  logic [1:0] relay_ff;
  logic [1:0] led_ff;
  logic [1:0] nvm_save_ff;
  logic [1:0] adj;
  logic flip_ff;
  logic show_ver_ff;
  logic health_ff;
  logic blink_ff;
  logic marker_ff;
  logic [31:0] ver_cnt_ff;
  logic [31:0] blink_cnt_ff;
  pres_t rdata_ff;
  pres_t rd_val;
  pres_t sel_val;
  pres_t analog_ff;
  pres_t disp_ff;

  assign rdata = rdata_ff;
  assign first_threshold_switch = relay_ff[0];
  assign second_threshold_switch = relay_ff[1];
  assign led = led_ff;
  assign analog_out = analog_ff;
  assign display_value = disp_ff;
  assign marker_blink = marker_ff;
  assign display_flip = flip_ff;
  assign show_version = show_ver_ff;
  assign health_indicator = health_ff;
  assign nvm_save = nvm_save_ff;

  // One identical slice per setpoint
  for (genvar g = 0; g < 2; g++)
  begin : g_sp
    logic deb_ff;
    logic deb_q_ff;
    logic dir_ff;
    logic [31:0] deb_cnt_ff;
    logic [31:0] tmr_ff;
    logic rise;
    logic fall;
    logic step;
    logic bump;
    logic tgt_low;
    logic nxt_lo;
    logic nxt_hi;
    logic [PW:0] lo_rel;
    pres_t hi_rel;
    pres_t nxt_thr;

    // Effective hysteresis: programmed value, or a tenth of the threshold
    assign lhe[g] = lcust_ff[g] ? lhys_ff[g] : tenth(lthr_ff[g]);
    assign hhe[g] = hcust_ff[g] ? hhys_ff[g] : tenth(hthr_ff[g]);
    // Release levels; widened sum so a high threshold cannot wrap
    assign lo_rel = {1'b0, lthr_ff[g]} + {1'b0, lhe[g]};
    assign hi_rel = (hthr_ff[g] > hhe[g]) ? hthr_ff[g] - hhe[g] : RANGE_MIN;
    assign nxt_lo = lo_act_ff[g] ? ({1'b0, pressure} < lo_rel) : (pressure < lthr_ff[g]);
    assign nxt_hi = hi_act_ff[g] ? (pressure > hi_rel) : (pressure > hthr_ff[g]);

    // Comparators with hysteresis and relay drive
    always_ff @(posedge sys_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        lo_act_ff[g] <= 1'b0;
        hi_act_ff[g] <= 1'b0;
        relay_ff[g] <= 1'b0;
      end
      else
      begin
        lo_act_ff[g] <= nxt_lo;
        hi_act_ff[g] <= nxt_hi;
        unique case (cfg_ff[g].mode)
          MODE_LOW: relay_ff[g] <= cfg_ff[g].low_en & nxt_lo;
          MODE_HIGH: relay_ff[g] <= cfg_ff[g].high_en & nxt_hi;
          MODE_BOTH: relay_ff[g] <= (cfg_ff[g].low_en & nxt_lo) | (cfg_ff[g].high_en & nxt_hi);
          default: relay_ff[g] <= 1'b0;
        endcase
      end
    end

    // Debounce: level must stay changed for the full window before it counts
    always_ff @(posedge sys_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        deb_ff <= 1'b0;
        deb_q_ff <= 1'b0;
        deb_cnt_ff <= '0;
      end
      else
      begin
        deb_q_ff <= deb_ff;
        if (threshold_button[g] == deb_ff)
          deb_cnt_ff <= '0;
        else if (deb_cnt_ff >= 32'(DEB_CYC - 1))
        begin
          deb_ff <= threshold_button[g];
          deb_cnt_ff <= '0;
        end
        else
          deb_cnt_ff <= deb_cnt_ff + 32'd1;
      end
    end

    assign rise = deb_ff & ~deb_q_ff;
    assign fall = ~deb_ff & deb_q_ff;
    assign step = (st_ff[g] == ADJ_HOLD) && deb_ff && (tmr_ff == 32'(STEP_CYC - 1));
    assign bump = (st_ff[g] == ADJ_WAIT) && rise && (tmr_ff < 32'(FINE_CYC));
    assign tgt_low = cfg_ff[g].mode != MODE_HIGH;
    assign cur_thr[g] = tgt_low ? lthr_ff[g] : hthr_ff[g];
    // Saturating one-unit move, clamped at the range ends
    assign nxt_thr = dir_ff ? ((cur_thr[g] == RANGE_MAX) ? cur_thr[g] : cur_thr[g] + 16'h0001)
                            : ((cur_thr[g] == RANGE_MIN) ? cur_thr[g] : cur_thr[g] - 16'h0001);

    // Button adjust sequence; one timer serves step rate and release windows
    always_ff @(posedge sys_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        st_ff[g] <= ADJ_IDLE;
        tmr_ff <= '0;
        dir_ff <= 1'b1;
        nvm_save_ff[g] <= 1'b0;
      end
      else
      begin
        nvm_save_ff[g] <= (st_ff[g] == ADJ_WAIT) && !rise && (tmr_ff >= 32'(SAVE_CYC));
        unique case (st_ff[g])
          ADJ_IDLE:
            if (rise)
            begin
              st_ff[g] <= ADJ_HOLD;
              tmr_ff <= '0;
              dir_ff <= 1'b1;
            end
          ADJ_HOLD:
            if (fall)
            begin
              st_ff[g] <= ADJ_WAIT;
              tmr_ff <= '0;
            end
            else if (tmr_ff >= 32'(STEP_CYC - 1))
              tmr_ff <= '0;
            else
              tmr_ff <= tmr_ff + 32'd1;
          ADJ_WAIT:
            if (rise)
            begin
              st_ff[g] <= ADJ_HOLD;
              tmr_ff <= '0;
              if (tmr_ff >= 32'(REV_LO_CYC) && tmr_ff < 32'(REV_HI_CYC))
                dir_ff <= ~dir_ff;
            end
            else if (tmr_ff >= 32'(SAVE_CYC))
              st_ff[g] <= ADJ_IDLE;
            else
              tmr_ff <= tmr_ff + 32'd1;
          default: st_ff[g] <= ADJ_IDLE;
        endcase
      end
    end

    // Setpoint settings; a button action wins over a port write in the same cycle
    always_ff @(posedge sys_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        lthr_ff[g] <= RANGE_MIN;
        hthr_ff[g] <= RANGE_MIN;
        lhys_ff[g] <= RANGE_MIN;
        hhys_ff[g] <= RANGE_MIN;
        lcust_ff[g] <= 1'b0;
        hcust_ff[g] <= 1'b0;
        cfg_ff[g] <= CFG_RST;
      end
      else
      begin
        if (bus_req.wr)
        begin
          if (sp_hit(bus_req.addr, g, O_LTHR))
            lthr_ff[g] <= bus_req.wdata;
          if (sp_hit(bus_req.addr, g, O_HTHR))
            hthr_ff[g] <= bus_req.wdata;
          if (sp_hit(bus_req.addr, g, O_LHYS))
          begin
            lhys_ff[g] <= bus_req.wdata;
            lcust_ff[g] <= 1'b1;
          end
          if (sp_hit(bus_req.addr, g, O_HHYS))
          begin
            hhys_ff[g] <= bus_req.wdata;
            hcust_ff[g] <= 1'b1;
          end
          if (sp_hit(bus_req.addr, g, O_CFG))
            cfg_ff[g] <= sp_cfg_t'(bus_req.wdata[3:0]);
        end
        if (rise)
        begin
          lcust_ff[g] <= 1'b0;
          hcust_ff[g] <= 1'b0;
        end
        if (step || bump)
        begin
          if (tgt_low)
            lthr_ff[g] <= nxt_thr;
          else
            hthr_ff[g] <= nxt_thr;
        end
      end
    end

    AST_LOW_TRIP: assert property ((cfg_ff[g].mode == MODE_LOW && cfg_ff[g].low_en
      && pressure < lthr_ff[g]) |=> relay_ff[g]) else $error("low trip relay open");
    AST_LOW_HYS: assert property ((cfg_ff[g].mode == MODE_LOW && cfg_ff[g].low_en
      && lo_act_ff[g] && {1'b0, pressure} < lo_rel) |=> relay_ff[g])
      else $error("relay released inside hysteresis band");
    AST_HIGH_TRIP: assert property ((cfg_ff[g].mode == MODE_HIGH && cfg_ff[g].high_en
      && pressure > hthr_ff[g]) |=> relay_ff[g]) else $error("high trip relay open");
    AST_BOTH: assert property ((cfg_ff[g].mode == MODE_BOTH && cfg_ff[g].low_en
      && cfg_ff[g].high_en && (pressure < lthr_ff[g] || pressure > hthr_ff[g]))
      |=> relay_ff[g]) else $error("combined trip relay open");
    AST_DISABLED: assert property (((cfg_ff[g].mode == MODE_LOW && !cfg_ff[g].low_en)
      || (cfg_ff[g].mode == MODE_HIGH && !cfg_ff[g].high_en)) |=> !relay_ff[g])
      else $error("disabled relay closed");
    AST_HYS_RESTORE: assert property (rise |=> !lcust_ff[g] && !hcust_ff[g])
      else $error("hysteresis not restored by press");
    AST_FINE: assert property ((bump && tgt_low && dir_ff && lthr_ff[g] != RANGE_MAX)
      |=> lthr_ff[g] == $past(lthr_ff[g]) + 16'h0001) else $error("fine step not one unit");
    AST_COMBINED_LOW: assert property ((cfg_ff[g].mode == MODE_BOTH && (step || bump)
      && !(bus_req.wr && sp_hit(bus_req.addr, g, O_HTHR))) |=> $stable(hthr_ff[g]))
      else $error("button moved high threshold");
    AST_SAVE: assert property (nvm_save_ff[g] |-> st_ff[g] == ADJ_IDLE
      && $past(st_ff[g]) == ADJ_WAIT) else $error("save outside release timeout");
    AST_LED_FLASH: assert property ((st_ff[g] != ADJ_IDLE) |=> led_ff[g] == $past(blink_ff))
      else $error("led not flashing while adjusting");
  end

  assign adj = {st_ff[1] != ADJ_IDLE, st_ff[0] != ADJ_IDLE};
  // First setpoint takes the output when both are being adjusted
  assign sel_val = adj[0] ? cur_thr[0] : (adj[1] ? cur_thr[1] : pressure);

  // Output substitution, version screen, indicators
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      analog_ff <= RANGE_MIN;
      disp_ff <= VERSION_CODE;
      led_ff <= 2'h0;
      marker_ff <= 1'b0;
      health_ff <= 1'b0;
    end
    else
    begin
      analog_ff <= sel_val;
      disp_ff <= show_ver_ff ? VERSION_CODE : sel_val;
      for (int i = 0; i < 2; i++)
        led_ff[i] <= adj[i] ? blink_ff : relay_ff[i];
      marker_ff <= (|adj) & blink_ff;
      health_ff <= ~show_ver_ff;
    end
  end

  // Power-up version timer and free-running blink
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      show_ver_ff <= 1'b1;
      ver_cnt_ff <= '0;
      blink_ff <= 1'b0;
      blink_cnt_ff <= '0;
    end
    else
    begin
      if (show_ver_ff)
      begin
        if (ver_cnt_ff >= 32'(VER_CYC - 1))
          show_ver_ff <= 1'b0;
        else
          ver_cnt_ff <= ver_cnt_ff + 32'd1;
      end
      if (blink_cnt_ff >= 32'(BLINK_CYC - 1))
      begin
        blink_cnt_ff <= '0;
        blink_ff <= ~blink_ff;
      end
      else
        blink_cnt_ff <= blink_cnt_ff + 32'd1;
    end
  end

  // Control register
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      flip_ff <= 1'b0;
    else if (bus_req.wr && bus_req.addr == A_CTRL)
      flip_ff <= bus_req.wdata[CTRL_FLIP_BIT];
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rd_val = '0;
    if (bus_req.addr == A_CTRL)
      rd_val[CTRL_FLIP_BIT] = flip_ff;
    if (bus_req.addr == A_STAT)
    begin
      rd_val[STAT_RELAY_LSB +: 2] = relay_ff;
      rd_val[STAT_ADJ_LSB +: 2] = adj;
      rd_val[STAT_VER_BIT] = show_ver_ff;
    end
    if (bus_req.addr == A_PRES)
      rd_val = pressure;
    for (int i = 0; i < 2; i++)
    begin
      if (sp_hit(bus_req.addr, i, O_LTHR))
        rd_val = lthr_ff[i];
      if (sp_hit(bus_req.addr, i, O_HTHR))
        rd_val = hthr_ff[i];
      if (sp_hit(bus_req.addr, i, O_LHYS))
        rd_val = lhe[i];
      if (sp_hit(bus_req.addr, i, O_HHYS))
        rd_val = hhe[i];
      if (sp_hit(bus_req.addr, i, O_CFG))
      begin
        rd_val[3:0] = cfg_ff[i];
        rd_val[CFG_LCUST_BIT] = lcust_ff[i];
        rd_val[CFG_HCUST_BIT] = hcust_ff[i];
      end
    end
  end

  // Read data stands for the single cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rdata_ff <= '0;
    else
      rdata_ff <= bus_req.rd ? rd_val : '0;
  end

  AST_SHOW_THR: assert property (adj[0] |=> analog_out == $past(cur_thr[0]))
    else $error("threshold not on output while adjusting");
  AST_FLIP: assert property ((bus_req.wr && bus_req.addr == A_CTRL)
    |=> display_flip == $past(bus_req.wdata[CTRL_FLIP_BIT])) else $error("flip not taken");

  COV_TRIP: cover property ($rose(relay_ff[0]));
  COV_BUMP: cover property (g_sp[0].bump);
  COV_SAVE: cover property (nvm_save_ff[0]);
  COV_SECOND: cover property (st_ff[1] == ADJ_HOLD);
endmodule

//--- bench/process_controller_model.sv
`timescale 1ns/1ps
// Process controller side: reads both relay contacts and the analog level
module process_controller_model
(
  input logic sys_clk,
  input logic rstn,
  input logic [1:0] contact,
  input setpoint_pkg::pres_t level,
  output logic [1:0] seen_contact,
  output setpoint_pkg::pres_t seen_level,
  output int closures
);
  import setpoint_pkg::*;

  // Registered scan, as a real input card adds one sample of delay
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      seen_contact <= 2'b00;
      seen_level <= 16'h0000;
    end
    else
    begin
      seen_contact <= contact;
      seen_level <= level;
    end
  end

  // Closure count exposes contact chatter around a threshold
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      closures <= 0;
    else
      closures <= closures + $countones(contact & ~seen_contact);
  end
endmodule

//--- bench/pressure_setpoint_switch_tb.sv
`timescale 1ns/1ps
module pressure_setpoint_switch_tb;
  import setpoint_pkg::*;
  logic sys_clk;
  logic rstn;
  bus_req_t bus_req;
  pres_t rdata, pressure, analog_out, display_value, seen_level, t1, v;
  logic [1:0] threshold_button, led, nvm_save, seen_contact;
  logic sw0, sw1, marker_blink, display_flip, show_version, health_indicator;
  int closures;
  int errors;
  int check_count;

  // Short timing set keeps the run brief; windows derive from these
  localparam int T_DEB = 4;
  localparam int T_STEP = 8;
  localparam int T_BLINK = 4;
  localparam int T_VER = 16;
  localparam int T_FINE = 20;
  localparam int T_REV_LO = 40;
  localparam int T_REV_HI = 60;
  localparam int T_SAVE = 100;

  pressure_setpoint_switch #(.DEB_CYC(T_DEB), .STEP_CYC(T_STEP), .BLINK_CYC(T_BLINK),
    .VER_CYC(T_VER), .FINE_CYC(T_FINE), .REV_LO_CYC(T_REV_LO), .REV_HI_CYC(T_REV_HI),
    .SAVE_CYC(T_SAVE)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
    .pressure(pressure), .threshold_button(threshold_button),
    .first_threshold_switch(sw0), .second_threshold_switch(sw1), .led(led),
    .analog_out(analog_out), .display_value(display_value),
    .marker_blink(marker_blink), .display_flip(display_flip),
    .show_version(show_version), .health_indicator(health_indicator),
    .nvm_save(nvm_save));

  process_controller_model ctl (.sys_clk(sys_clk), .rstn(rstn), .contact({sw1, sw0}),
    .level(analog_out), .seen_contact(seen_contact), .seen_level(seen_level),
    .closures(closures));

  // Free-running system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk(input string what, input pres_t exp, input pres_t got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic addr_t sa(input int n, input int o);
    return addr_t'(A_SP0 + n * A_SP_STRIDE + o);
  endfunction

  // Register port: one-cycle strobes, read data only in the following cycle
  task automatic wr(input addr_t a, input pres_t d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input addr_t a, output pres_t d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Relay reaches the controller within three edges; LED changes on the same edge
  task automatic lvl(input pres_t p, input logic [1:0] e, input string what);
    @(posedge sys_clk);
    pressure <= p;
    tick(4);
    #1;
    chk(what, {12'h000, e, e}, {12'h000, led, seen_contact});
  endtask

  task automatic push(input int n, input int held);
    @(posedge sys_clk);
    threshold_button[n] <= 1'b1;
    tick(held);
    threshold_button[n] <= 1'b0;
  endtask

  // Store pulse must come and last a single cycle
  task automatic wait_save(input int n);
    int k;
    k = 0;
    while (nvm_save[n] !== 1'b1 && k < T_SAVE + 40)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk("nvm_save", 16'h0001, {15'h0000, nvm_save[n]});
    @(posedge sys_clk);
    #1;
    chk("nvm_save width", 16'h0000, {15'h0000, nvm_save[n]});
  endtask

  task automatic t_reset;
    #1;
    chk("version flag", 16'h0001, {15'h0000, show_version});
    chk("version shown", VERSION_CODE, display_value);
    rd(sa(0, O_LTHR), v);
    chk("sp0 low thr", RANGE_MIN, v);
    rd(sa(1, O_HTHR), v);
    chk("sp1 high thr", RANGE_MIN, v);
    rd(sa(0, O_CFG), v);
    chk("sp0 cfg", 16'h000c, v);
    tick(20);
    #1;
    chk("version over", 16'h0000, {15'h0000, show_version});
    chk("health", 16'h0001, {15'h0000, health_indicator});
    chk("relays idle", 16'h0000, {14'h0000, seen_contact});
    $display("test reset done");
  endtask

  task automatic t_low;
    lvl(16'd5000, 2'b00, "above");
    wr(sa(0, O_LTHR), 16'd1000);
    rd(sa(0, O_LTHR), v);
    chk("thr readback", 16'd1000, v);
    rd(sa(0, O_LHYS), v);
    chk("default hyst", 16'd100, v);
    lvl(16'd1000, 2'b00, "at thr");
    lvl(16'd999, 2'b01, "below thr");
    lvl(16'd1099, 2'b01, "low band");
    lvl(16'd1100, 2'b00, "low release");
    chk("closures", 16'd1, 16'(closures));
    // Disable the low trip so the first setpoint stays quiet in the high test
    wr(sa(0, O_CFG), 16'h0008);
    lvl(16'd999, 2'b00, "low disabled");
    $display("test low done");
  endtask

  task automatic t_high;
    wr(sa(1, O_HTHR), 16'd1000);
    lvl(16'd800, 2'b00, "low mode idle");
    wr(sa(1, O_CFG), 16'h000d);
    lvl(16'd1000, 2'b00, "at high thr");
    lvl(16'd1001, 2'b10, "above high");
    lvl(16'd901, 2'b10, "high band");
    lvl(16'd900, 2'b00, "high release");
    lvl(16'd1001, 2'b10, "above again");
    wr(sa(1, O_CFG), 16'h0005);
    lvl(16'd1001, 2'b00, "disabled");
    $display("test high done");
  endtask

  task automatic t_both;
    wr(sa(0, O_HTHR), 16'd2000);
    wr(sa(0, O_CFG), 16'h000e);
    lvl(16'd2001, 2'b01, "over high");
    lvl(16'd1500, 2'b00, "between");
    lvl(16'd999, 2'b01, "under low");
    $display("test both done");
  endtask

  task automatic t_button;
    logic [1:0] b;
    logic [1:0] l;
    wr(sa(0, O_CFG), 16'h000c);
    lvl(16'hf000, 2'b00, "high pressure");
    wr(sa(0, O_LHYS), 16'd50);
    rd(sa(0, O_CFG), v);
    chk("hyst flag set", 16'h0001, {15'h0000, v[CFG_LCUST_BIT]});
    push(0, 40);
    tick(3);
    rd(sa(0, O_LTHR), t1);
    chk("thr rose", 16'h0001, {15'h0000, t1 > 16'd1000});
    chk("analog thr", t1, analog_out);
    chk("controller level", t1, seen_level);
    chk("display thr", t1, display_value);
    b = 2'b00;
    l = 2'b00;
    // Both levels must show within one blink period
    repeat (8)
    begin
      @(posedge sys_clk);
      #1;
      b = b | (marker_blink ? 2'b10 : 2'b01);
      l = l | (led[0] ? 2'b10 : 2'b01);
    end
    chk("marker blinks", 16'h0003, {14'h0000, b});
    chk("led flashes", 16'h0003, {14'h0000, l});
    push(0, 6);
    tick(8);
    rd(sa(0, O_LTHR), v);
    chk("fine step", t1 + 16'd1, v);
    tick(35);
    push(0, 6);
    tick(8);
    push(0, 6);
    tick(8);
    rd(sa(0, O_LTHR), v);
    chk("reversed step", t1, v);
    wait_save(0);
    chk("back to pressure", pressure, analog_out);
    rd(sa(0, O_CFG), v);
    chk("hyst flag cleared", 16'h0000, {15'h0000, v[CFG_LCUST_BIT]});
    rd(sa(0, O_LHYS), v);
    chk("hyst default", t1 / 16'd10, v);
    $display("test button done");
  endtask

  task automatic t_second;
    wr(sa(1, O_CFG), 16'h000e);
    wr(sa(1, O_LTHR), 16'd500);
    wr(sa(1, O_HTHR), 16'd3000);
    push(1, 30);
    tick(2);
    rd(sa(1, O_LTHR), v);
    chk("sp1 low moved", 16'h0001, {15'h0000, v > 16'd500});
    rd(sa(1, O_HTHR), v);
    chk("sp1 high kept", 16'd3000, v);
    rd(sa(1, O_CFG), v);
    chk("sp1 mode kept", 16'h000e, v);
    wait_save(1);
    $display("test second done");
  endtask

  task automatic t_flip;
    wr(A_CTRL, 16'h0001);
    #1;
    chk("flip", 16'h0001, {15'h0000, display_flip});
    rd(A_CTRL, v);
    chk("ctrl readback", 16'h0001, v);
    rd(8'h3f, v);
    chk("unmapped", 16'h0000, v);
    $display("test flip done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog: tests need about 530 cycles
  initial
  begin
    tick(20000);
    errors++;
    $display("MISMATCH watchdog expected done seen timeout");
    complete_run();
  end

  // Main sequence
  initial
  begin
    errors = 0;
    check_count = 0;
    rstn = 1'b0;
    bus_req = '0;
    pressure = 16'h0000;
    threshold_button = 2'b00;
    tick(4);
    rstn <= 1'b1;
    t_reset();
    t_low();
    t_high();
    t_both();
    t_button();
    t_second();
    t_flip();
    complete_run();
  end
endmodule
